/* bcp_core_pins.sv */
// Core bus control pins: cycle indicators, reset sequencing, interrupts
`timescale 1ns/1ps
module bcp_core_pins
  import bcp_pkg::*;
#(
  parameter int AW = BCP_ADDR_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic core_reset_n,
  input wire logic wait_stretch_n,
  input wire logic fast_irq_req_n,
  input wire logic normal_irq_req_n,
  input wire logic irq_sync_select,
  input wire logic req_valid,
  input wire logic req_fetch,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic dcc_to_core,
  input wire logic exec_cond_fail,
  input wire logic [BCP_MODE_W-1:0] cpu_mode,
  input wire logic fiq_enable,
  input wire logic irq_enable,
  output logic write_drive_active_n,
  output logic comms_transfer_active_n,
  output logic instr_skipped_n,
  output logic [BCP_MODE_W-1:0] cpu_mode_inv,
  output logic mem_request_n,
  output logic opcode_fetch_n,
  output logic read_write_dir,
  output logic privileged_access_n,
  output logic [AW-1:0] address,
  output logic fast_irq_take,
  output logic normal_irq_take,
  output logic instr_abort,
  output logic core_step
);
  typedef struct packed {
    logic [BCP_SYNC_STAGES-1:0] rst_sync;
    logic [BCP_SYNC_STAGES-1:0] wait_sync;
    bcp_phase_t phase;
    logic pend;
    logic p_fetch;
    logic p_write;
    logic [AW-1:0] p_addr;
    logic [AW-1:0] addr;
    logic mreq_n;
    logic opc_n;
    logic rw;
    logic wen_n;
    logic dcc_n;
    logic skip_n;
    logic [BCP_MODE_W-1:0] mode_inv;
    logic trans_n;
    logic fiq_take;
    logic irq_take;
    logic abort;
    logic step;
  } bcp_state_t;

  bcp_state_t s;
  bcp_state_t next_s;
  logic rst_ok;
  logic go;
  logic fiq_hit;

  bcp_irq_if irq_bus ();

  // Interrupt pins conditioned in their own module
  bcp_irq_cond u_irq_cond (
    .clk(clk),
    .rst(rst),
    .fast_irq_req_n(fast_irq_req_n),
    .normal_irq_req_n(normal_irq_req_n),
    .irq_sync_select(irq_sync_select),
    .irq(irq_bus.cond)
  );

  // Only the second synchroniser stage is ever looked at
  assign rst_ok = s.rst_sync[BCP_SYNC_STAGES-1];
  assign go = s.wait_sync[BCP_SYNC_STAGES-1];
  assign fiq_hit = irq_bus.fast_req & fiq_enable;

  // Next-state logic for the whole pin block
  always_comb begin
    next_s = s;
    next_s.rst_sync = {s.rst_sync[0], core_reset_n};
    next_s.wait_sync = {s.wait_sync[0], wait_stretch_n};
    next_s.abort = 1'b0;
    next_s.fiq_take = 1'b0;
    next_s.irq_take = 1'b0;
    // Progress enable stands in for the gated clock; no real gating
    next_s.step = go & rst_ok;
    // Mode status follows the core every cycle, even while stretched
    next_s.mode_inv = ~cpu_mode;
    next_s.trans_n = (cpu_mode != BCP_MODE_USER);
    unique case (s.phase)
      BCP_RUN: begin
        if (!rst_ok) begin
          next_s.phase = BCP_RESET;
          next_s.abort = 1'b1;
          next_s.pend = 1'b0;
          next_s.mreq_n = BCP_PIN_IDLE_N;
          next_s.opc_n = BCP_PIN_IDLE_N;
          next_s.rw = BCP_DIR_READ;
          next_s.wen_n = BCP_PIN_IDLE_N;
          next_s.dcc_n = BCP_PIN_IDLE_N;
        end else if (go) begin
          // Access announced last cycle is presented now
          next_s.wen_n = !(s.pend && s.p_write);
          next_s.rw = s.pend && s.p_write;
          next_s.opc_n = !(s.pend && s.p_fetch);
          if (s.pend) begin
            next_s.addr = s.p_addr;
          end
          // One cycle of advance notice for the next access
          next_s.mreq_n = !req_valid;
          next_s.pend = req_valid;
          next_s.p_fetch = req_fetch;
          next_s.p_write = req_write;
          next_s.p_addr = req_addr;
          next_s.dcc_n = !dcc_to_core;
          next_s.skip_n = exec_cond_fail;
          next_s.fiq_take = fiq_hit;
          next_s.irq_take = irq_bus.normal_req & irq_enable & !fiq_hit;
        end
        // Wait low: every access field holds, stretching the cycle
      end
      BCP_RESET: begin
        // Internal cycles; natural overflow wraps to zero
        next_s.addr = AW'(s.addr + 1'b1);
        if (rst_ok) begin
          next_s.phase = BCP_RESTART;
        end
      end
      BCP_RESTART: begin
        if (!rst_ok) begin
          next_s.phase = BCP_RESET;
        end else begin
          // Reset high one cycle: announce fetch from restart address
          next_s.phase = BCP_RUN;
          next_s.mreq_n = 1'b0;
          next_s.pend = 1'b1;
          next_s.p_fetch = 1'b1;
          next_s.p_write = 1'b0;
          next_s.p_addr = AW'(BCP_RESTART_ADDR);
        end
      end
      default: begin
        next_s.phase = BCP_RESET;
      end
    endcase
  end

  // Single memory clock for every operation
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.rst_sync <= '0;
      s.phase <= BCP_RESET;
      s.mreq_n <= BCP_PIN_IDLE_N;
      s.opc_n <= BCP_PIN_IDLE_N;
      s.wen_n <= BCP_PIN_IDLE_N;
      s.dcc_n <= BCP_PIN_IDLE_N;
      s.mode_inv <= '1;
      s.trans_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Pins straight from the state register
  assign write_drive_active_n = s.wen_n;
  assign comms_transfer_active_n = s.dcc_n;
  assign instr_skipped_n = s.skip_n;
  assign cpu_mode_inv = s.mode_inv;
  assign mem_request_n = s.mreq_n;
  assign opcode_fetch_n = s.opc_n;
  assign read_write_dir = s.rw;
  assign privileged_access_n = s.trans_n;
  assign address = s.addr;
  assign fast_irq_take = s.fiq_take;
  assign normal_irq_take = s.irq_take;
  assign instr_abort = s.abort;
  assign core_step = s.step;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_run_step;
    s.phase == BCP_RUN && rst_ok && go;
  endsequence
  sequence seq_reset_entry;
    s.phase == BCP_RUN && !rst_ok;
  endsequence
  sequence seq_restart;
    s.phase == BCP_RESTART && rst_ok;
  endsequence

  a_write_cycle: assert property (seq_run_step ##0 (s.pend && s.p_write) |=>
    (!write_drive_active_n && read_write_dir))
    else $error("write cycle without low write indicator");
  a_write_idle: assert property (seq_run_step ##0 !(s.pend && s.p_write) |=>
    (write_drive_active_n && !read_write_dir))
    else $error("write indicator low outside write cycle");
  a_comms_xfer: assert property (seq_run_step ##0 dcc_to_core |=> !comms_transfer_active_n)
    else $error("comms transfer indicator not low");
  a_skip_flag: assert property (seq_run_step |=> instr_skipped_n == $past(exec_cond_fail))
    else $error("skip indicator wrong");
  a_fiq_wins: assert property (seq_run_step ##0 fiq_hit |=> fast_irq_take && !normal_irq_take)
    else $error("fast interrupt not taken first");
  a_irq_gate: assert property (!irq_enable |=> !normal_irq_take)
    else $error("normal interrupt taken while disabled");
  a_mode_bus: assert property (1'b1 |=> cpu_mode_inv == ~$past(cpu_mode))
    else $error("mode bus not inverted mode");
  a_user_trans: assert property (1'b1 |=> privileged_access_n == ($past(cpu_mode) != BCP_MODE_USER))
    else $error("translate indicator wrong");
  a_req_notice: assert property (seq_run_step ##0 req_valid |=> !mem_request_n)
    else $error("memory request notice missing");
  a_fetch_ind: assert property (seq_run_step ##0 (s.pend && s.p_fetch) |=> !opcode_fetch_n)
    else $error("fetch indicator not low");
  a_reset_abort: assert property (seq_reset_entry |=> instr_abort && mem_request_n)
    else $error("reset did not abort");
  a_reset_count: assert property (s.phase == BCP_RESET |=> address == AW'($past(address) + 1'b1))
    else $error("reset address not incrementing");
  // The first step after restart presents the fetch announced by the restart cycle
  a_restart_zero: assert property (seq_restart ##1 seq_run_step |=>
    (address == '0 && !opcode_fetch_n))
    else $error("restart not fetching from zero");
  a_restart_notice: assert property (seq_restart |=> !mem_request_n)
    else $error("restart fetch not announced");
  a_wait_hold: assert property (s.phase == BCP_RUN && rst_ok && !go |=>
    $stable(address) && $stable(read_write_dir) && $stable(mem_request_n))
    else $error("access not stretched by wait");
  a_step_gate: assert property (1'b1 |=> core_step == $past(go && rst_ok))
    else $error("progress enable not gated by wait");
endmodule : bcp_core_pins

/* bcp_pkg.sv */
// Shared constants and types for the bus control pin block
package bcp_pkg;
  // Address bus width and restart address
  localparam int BCP_ADDR_W = 32;
  localparam logic [31:0] BCP_RESTART_ADDR = 32'h0000_0000;
  // Processor mode width and the one unprivileged mode code
  localparam int BCP_MODE_W = 5;
  localparam logic [4:0] BCP_MODE_USER = 5'h10;
  // Reset values of the active-low request, fetch, write and comms pins (released) and of the direction pin (read)
  localparam logic BCP_PIN_IDLE_N = 1'b1;
  localparam logic BCP_DIR_READ = 1'b0;
  // Synchroniser depth for pins from outside the clock domain
  localparam int BCP_SYNC_STAGES = 2;
  // Number of interrupt inputs: fast and normal
  localparam int BCP_IRQ_N = 2;
  localparam int BCP_IRQ_FAST = 1;
  localparam int BCP_IRQ_NORM = 0;
  // Core sequencing phases, Gray coded along run, reset, restart
  typedef enum logic [1:0] {
    BCP_RUN = 2'b00,
    BCP_RESET = 2'b01,
    BCP_RESTART = 2'b11
  } bcp_phase_t;
endpackage : bcp_pkg

/* bcp_irq_if.sv */
// Conditioned interrupt requests passed from conditioner to core logic
`timescale 1ns/1ps
interface bcp_irq_if;
  logic fast_req;
  logic normal_req;
  modport cond (output fast_req, output normal_req);
  modport core (input fast_req, input normal_req);
endinterface : bcp_irq_if

/* bcp_irq_cond.sv */
// Interrupt pin conditioner: synchronised or direct capture per mode
`timescale 1ns/1ps
module bcp_irq_cond
  import bcp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic fast_irq_req_n,
  input wire logic normal_irq_req_n,
  input wire logic irq_sync_select,
  bcp_irq_if.cond irq
);
  typedef struct packed {
    logic [BCP_IRQ_N-1:0] meta;
    logic [BCP_IRQ_N-1:0] stable;
    logic [BCP_IRQ_N-1:0] direct;
    logic sel_sync;
    logic [BCP_IRQ_N-1:0] req;
  } bcp_cond_t;

  bcp_cond_t s;
  bcp_cond_t next_s;
  logic [BCP_IRQ_N-1:0] pins;

  assign pins = {~fast_irq_req_n, ~normal_irq_req_n};

  // Synchronous pins skip the metastability stage to save a cycle
  always_comb begin
    next_s = s;
    next_s.sel_sync = irq_sync_select;
    for (int i = 0; i < BCP_IRQ_N; i++) begin
      next_s.meta[i] = pins[i];
      next_s.stable[i] = s.meta[i];
      next_s.direct[i] = pins[i];
      next_s.req[i] = s.sel_sync ? s.direct[i] : s.stable[i];
    end
  end

  // Requests cleared at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign irq.fast_req = s.req[BCP_IRQ_FAST];
  assign irq.normal_req = s.req[BCP_IRQ_NORM];

  a_async_path: assert property (@(posedge clk) disable iff (rst)
    (!s.sel_sync && s.stable[BCP_IRQ_FAST]) |=> irq.fast_req)
    else $error("async fast request not forwarded");
endmodule : bcp_irq_cond

/* bcp_mem_model.sv */
// Memory controller model: wait insertion and interrupt sources
`timescale 1ns/1ps
module bcp_mem_model (
  input wire logic clk,
  input wire logic mem_request_n,
  input wire logic [3:0] stall,
  input wire logic fire_fast,
  input wire logic fire_norm,
  input wire logic fast_irq_take,
  input wire logic normal_irq_take,
  output logic wait_stretch_n,
  output logic fast_irq_req_n,
  output logic normal_irq_req_n
);
  logic [3:0] cnt = 4'h0;
  logic hf = 1'b0;
  logic hn = 1'b0;
  // Everything moves on the falling edge, so wait and requests are settled by the next rising edge
  always @(negedge clk) begin
    if (cnt != 4'h0) cnt <= cnt - 4'h1;
    else if (!mem_request_n) cnt <= stall;
    hf <= fire_fast | (hf & !fast_irq_take);
    hn <= fire_norm | (hn & !normal_irq_take);
  end
  // A zero stall keeps wait high for good
  assign wait_stretch_n = (cnt == 4'h0);
  assign fast_irq_req_n = !hf;
  assign normal_irq_req_n = !hn;
endmodule : bcp_mem_model

/* bcp_core_pins_tb_top.sv */
// Testbench for the bus control pin block
`timescale 1ns/1ps
module bcp_core_pins_tb_top;
  import bcp_pkg::*;
  logic clk, rst, crn, sync, rv, rf, wr, dcc, fail, fe, ie, ff, fn;
  logic wn, fq_n, nq_n, wd_n, ct_n, sk_n, mr_n, op_n, rwd, pa_n, fit, nit, ab, step;
  logic [4:0] mode, minv;
  logic [7:0] ra, addr, a0;
  logic [3:0] stall, ex;
  // Rows: valid fetch write comms fail mode addr, then mreq rw wd opfetch
  logic [21:0] rows[5] = '{22'h31_0402, 22'h2D_3815, 22'h23_1FF3, 22'h01_F00A, 22'h31_2012};
  int err_total = 0;
  int cmp_count = 0;
  int nf[2];
  int i;

  // Small address bus so the reset incrementer wraps quickly
  bcp_core_pins #(.AW(8)) uut (.clk(clk), .rst(rst), .core_reset_n(crn), .wait_stretch_n(wn),
    .fast_irq_req_n(fq_n), .normal_irq_req_n(nq_n), .irq_sync_select(sync), .req_valid(rv),
    .req_fetch(rf), .req_write(wr), .req_addr(ra), .dcc_to_core(dcc), .exec_cond_fail(fail),
    .cpu_mode(mode), .fiq_enable(fe), .irq_enable(ie), .write_drive_active_n(wd_n),
    .comms_transfer_active_n(ct_n), .instr_skipped_n(sk_n), .cpu_mode_inv(minv),
    .mem_request_n(mr_n), .opcode_fetch_n(op_n), .read_write_dir(rwd), .privileged_access_n(pa_n),
    .address(addr), .fast_irq_take(fit), .normal_irq_take(nit), .instr_abort(ab), .core_step(step));

  bcp_mem_model pm (.clk(clk), .mem_request_n(mr_n), .stall(stall), .fire_fast(ff), .fire_norm(fn),
    .fast_irq_take(fit), .normal_irq_take(nit), .wait_stretch_n(wn), .fast_irq_req_n(fq_n),
    .normal_irq_req_n(nq_n));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Inputs move 1 ns after the edge, outputs are settled by then
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask : chk

  // Bounded wait on a flag, returns the edges spent
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n, input string what);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
    chk(s, v, what);
  endtask : wait_for

  task end_sim;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Run is well under 2000 cycles
  initial begin
    #50000;
    err_total++;
    end_sim;
  end

  initial begin
    {rst, crn, sync, rv, rf, wr, dcc, fail, fe, ie, ff, fn} = 12'h800;
    mode = 5'h13;
    ra = 8'h00;
    stall = 4'h0;
    tick(4);
    chk(mr_n, 1'b1, "rst mreq");
    chk(minv, 5'h1F, "rst mode");
    chk(addr, 8'h00, "rst addr");
    chk(step, 1'b0, "rst step");
    rst = 1'b0;
    tick(4);
    a0 = addr;
    tick(1);
    chk(addr, 8'(a0 + 8'h01), "reset incr");
    crn = 1'b1;
    wait_for(op_n, 1'b0, 8, nf[0], "restart fetch");
    chk(addr, BCP_RESTART_ADDR[7:0], "restart addr");
    $display("reset test done");
    // Each row is held two edges: one-cycle fields first, access fields next
    foreach (rows[k]) begin
      {rv, rf, wr, dcc, fail, mode, ra, ex} = rows[k];
      tick(1);
      chk(mr_n, ex[3], "mreq");
      chk(minv, 5'(~mode), "mode inv");
      chk(pa_n, mode != BCP_MODE_USER, "translate");
      chk(ct_n, !dcc, "comms");
      chk(sk_n, fail, "skipped");
      tick(1);
      chk(rwd, ex[2], "dir");
      chk(wd_n, ex[1], "write ind");
      if (rv) chk(op_n, ex[0], "opfetch");
      if (rv) chk(addr, ra, "addr");
    end
    $display("row test done");
    // Stalled write: a changed request must not leak through
    stall = 4'h6;
    {rv, rf, wr, ra} = 11'h555;
    wait_for(step, 1'b0, 8, nf[0], "stall seen");
    a0 = addr;
    ra = 8'hAA;
    stall = 4'h0;
    tick(2);
    chk(addr, a0, "stall hold");
    chk(step, 1'b0, "stall step");
    wait_for(step, 1'b1, 12, nf[0], "stall end");
    chk(addr, a0, "stall resume");
    rv = 1'b0;
    tick(4);
    $display("wait test done");
    // Async capture costs one extra edge over sync capture
    for (int s = 0; s < 2; s++) begin
      sync = s[0];
      fe = 1'b1;
      ff = 1'b1;
      tick(1);
      ff = 1'b0;
      wait_for(fit, 1'b1, 8, nf[s], "fast take");
      tick(8);
    end
    chk(nf[0], nf[1] + 1, "sync latency");
    fe = 1'b0;
    ff = 1'b1;
    tick(1);
    ff = 1'b0;
    tick(8);
    chk(fit, 1'b0, "fast masked");
    fe = 1'b1;
    wait_for(fit, 1'b1, 6, nf[0], "fast level held");
    tick(8);
    // Both pending: fast first, normal after
    ie = 1'b1;
    {ff, fn} = 2'b11;
    tick(1);
    {ff, fn} = 2'b00;
    wait_for(fit, 1'b1, 8, nf[0], "prio fast");
    chk(nit, 1'b0, "prio normal held");
    wait_for(nit, 1'b1, 12, nf[0], "normal take");
    tick(8);
    // Normal request held while disabled, taken once enabled
    ie = 1'b0;
    fn = 1'b1;
    tick(1);
    fn = 1'b0;
    tick(8);
    chk(nit, 1'b0, "normal masked");
    ie = 1'b1;
    wait_for(nit, 1'b1, 6, nf[0], "normal level held");
    tick(8);
    $display("irq test done");
    // Mid-run reset aborts, then the incrementer wraps
    crn = 1'b0;
    wait_for(ab, 1'b1, 6, nf[0], "abort");
    chk(mr_n, 1'b1, "abort mreq");
    i = 0;
    while (addr !== 8'hFF && i < 300) begin
      tick(1);
      i++;
    end
    tick(1);
    chk(addr, 8'h00, "wrap");
    $display("abort test done");
    end_sim;
  end
endmodule : bcp_core_pins_tb_top
